// File: pkg/spsr_pkg.sv
// Purpose: shared constants and carrier types for the spi status/data block
// Assumes: apb3 slave, 32-bit data, one word per register
// Notes:   register index kept as printed, byte address is four times it

package spsr_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0]  IDX_DATA    = 8'h21;
  localparam logic [7:0]  IDX_CTRL    = 8'h22;
  localparam logic [7:0]  IDX_STAT    = 8'h23;
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] ADDR_DATA   = {2'h0, IDX_DATA, 2'h0};
  localparam logic [11:0] ADDR_CTRL   = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_STAT   = {2'h0, IDX_STAT, 2'h0};

  // ==========================================================
  // control register fields
  localparam int CR_IRQ_EN  = 7;
  localparam int CR_PERIPH  = 6;
  localparam int CR_RATEDIV = 5;
  localparam int CR_MASTER  = 4;
  localparam int CR_CPOL    = 3;
  localparam int CR_CPHA    = 2;
  localparam int CR_RATE_HI = 1;
  localparam int CR_RATE_LO = 0;
  localparam logic [7:0] CR_RESET = 8'h00;

  // ==========================================================
  // control/status register fields
  localparam int SR_DONE   = 7;
  localparam int SR_WRITE_COLLISION_FLAG   = 6;
  localparam int SR_OVR    = 5;
  localparam int SR_MASTER_FAULT_FLAG   = 4;
  localparam int SR_RSVD   = 3;
  localparam int SR_SOD    = 2;
  localparam int SR_SSM    = 1;
  localparam int SR_SSI    = 0;
  localparam logic [7:0] SR_RESET = 8'h00;

  // ==========================================================
  // half-period counts of the serial clock, per rate code
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV8   = 7'h04;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV32  = 7'h10;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [3:0] LAST_EDGE   = 4'hf;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } spsr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spsr_apb_rsp_t;

  typedef struct packed {
    logic sckIn;
    logic mosiIn;
    logic misoIn;
    logic ssN;
  } spsr_pin_in_t;

  typedef struct packed {
    logic sckOut;
    logic sckOe;
    logic mosiOut;
    logic mosiOe;
    logic misoOut;
    logic misoOe;
  } spsr_pin_out_t;

endpackage : spsr_pkg

// File: rtl/spsr_rate_div.sv
// Purpose: master serial clock rate divider, one-cycle tick per half period
// Assumes: run low between transfers restarts the count
// Notes:   unused rate codes fall back to the slowest rate

`timescale 1ns/1ps

module spsr_rate_div (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic [2:0] rate,
  // half-period enable
  output logic            tick
);

  // ==========================================================
  // rate decode
  logic [6:0] halfCnt;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;

  assign halfCnt = (rate == 3'b100) ? spsr_pkg::HALF_DIV4 :
                   (rate == 3'b000) ? spsr_pkg::HALF_DIV8 :
                   (rate == 3'b001) ? spsr_pkg::HALF_DIV16 :
                   (rate == 3'b110) ? spsr_pkg::HALF_DIV32 :
                   (rate == 3'b010) ? spsr_pkg::HALF_DIV64 :
                   spsr_pkg::HALF_DIV128;

  // ==========================================================
  // counter
  assign tick  = run && (cnt_q == halfCnt - 7'h01);
  assign cnt_d = (!run || tick) ? 7'h00 : cnt_q + 7'h01;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : spsr_rate_div

// File: rtl/spsr_pin_drive.sv
// Purpose: drive levels and enables of the serial pins
// Assumes: all inputs come from flip-flops of the core
// Notes:   the pad ring resolves the wire from the enables

`timescale 1ns/1ps

module spsr_pin_drive (
  // configuration
  input  wire logic                  periphEn,
  input  wire logic                  masterSel,
  input  wire logic                  outDisable,
  input  wire logic                  cpol,
  // engine state
  input  wire logic                  sckLevel,
  input  wire logic                  txBit,
  // pins
  output spsr_pkg::spsr_pin_out_t    pinOut
);

  // ==========================================================
  // clock pin is driven only as master, idle level from cpol
  assign pinOut.sckOut  = cpol ^ sckLevel;
  assign pinOut.sckOe   = periphEn && masterSel;

  // ==========================================================
  // data out pin swaps with mode, silenced by the output disable
  assign pinOut.mosiOut = txBit;
  assign pinOut.mosiOe  = periphEn && masterSel && !outDisable;
  assign pinOut.misoOut = txBit;
  assign pinOut.misoOe  = periphEn && !masterSel && !outDisable;

endmodule : spsr_pin_drive

// File: rtl/spsr_core.sv
// Purpose: spi status, control and data registers with the byte shifter
// Assumes: apb3 slave, zero wait states; pins synchronous to clock
// Notes:   one shift register serves transmit and receive
//
// Chosen here: register access over APB.

`timescale 1ns/1ps

module spsr_core (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // register bus
  input  wire spsr_pkg::spsr_apb_req_t apbReq,
  output spsr_pkg::spsr_apb_rsp_t    apbRsp,
  // serial pins
  input  wire spsr_pkg::spsr_pin_in_t  pinIn,
  output spsr_pkg::spsr_pin_out_t    pinOut,
  // interrupt request
  output logic                       irq
);

  // ==========================================================
  // state
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic       doneFlag_q;
  logic       doneFlag_d;
  logic       wcolFlag_q;
  logic       wcolFlag_d;
  logic       ovrFlag_q;
  logic       ovrFlag_d;
  logic       modfFlag_q;
  logic       modfFlag_d;
  logic [2:0] selCtl_q;
  logic [2:0] selCtl_d;
  logic       armed_q;
  logic       armed_d;
  logic       modfArmed_q;
  logic       modfArmed_d;
  logic [7:0] rxBuf_q;
  logic [7:0] rxBuf_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic       rxBit_q;
  logic       rxBit_d;
  logic [3:0] edgeIdx_q;
  logic [3:0] edgeIdx_d;
  logic       active_q;
  logic       active_d;
  logic       sckLevel_q;
  logic       sckLevel_d;
  logic       sckPrev_q;

  // ==========================================================
  // bus decode
  logic       apbAccess;
  logic       busWr;
  logic       busRd;
  logic       hitData;
  logic       hitCtrl;
  logic       hitStat;
  logic       hitAny;

  assign apbAccess = apbReq.psel && apbReq.penable;
  assign busWr     = apbAccess && apbReq.pwrite;
  assign busRd     = apbAccess && !apbReq.pwrite;
  assign hitData   = apbReq.paddr == spsr_pkg::ADDR_DATA;
  assign hitCtrl   = apbReq.paddr == spsr_pkg::ADDR_CTRL;
  assign hitStat   = apbReq.paddr == spsr_pkg::ADDR_STAT;
  assign hitAny    = hitData || hitCtrl || hitStat;

  logic       dataAcc;
  logic       dataWr;
  logic       ctrlWr;
  logic       statWr;
  logic       statRd;

  assign dataAcc = apbAccess && hitData;
  assign dataWr  = busWr && hitData;
  assign ctrlWr  = busWr && hitCtrl;
  assign statWr  = busWr && hitStat;
  assign statRd  = busRd && hitStat;

  // ==========================================================
  // configuration views
  logic       irqEn;
  logic       periphEn;
  logic       masterSel;
  logic       cpol;
  logic       cpha;
  logic [2:0] rateSel;
  logic       outDisable;
  logic       softSelMode;
  logic       softSelLevel;
  logic       selectN;

  assign irqEn        = ctrl_q[spsr_pkg::CR_IRQ_EN];
  assign periphEn     = ctrl_q[spsr_pkg::CR_PERIPH];
  assign masterSel    = ctrl_q[spsr_pkg::CR_MASTER];
  assign cpol         = ctrl_q[spsr_pkg::CR_CPOL];
  assign cpha         = ctrl_q[spsr_pkg::CR_CPHA];
  assign rateSel      = {ctrl_q[spsr_pkg::CR_RATEDIV],
                         ctrl_q[spsr_pkg::CR_RATE_HI],
                         ctrl_q[spsr_pkg::CR_RATE_LO]};
  assign outDisable   = selCtl_q[spsr_pkg::SR_SOD];
  assign softSelMode  = selCtl_q[spsr_pkg::SR_SSM];
  assign softSelLevel = selCtl_q[spsr_pkg::SR_SSI];
  assign selectN      = softSelMode ? softSelLevel : pinIn.ssN;

  // ==========================================================
  // shift engine edges
  logic       masterTick;
  logic       masterOn;
  logic       slaveSel;
  logic       slaveEdge;
  logic       edgeEv;
  logic       sampleEdge;
  logic       finalEdge;
  logic       serIn;
  logic       busy;
  logic       xferDone;

  assign masterOn   = periphEn && masterSel;
  assign slaveSel   = periphEn && !masterSel && !selectN;
  assign slaveEdge  = slaveSel && (pinIn.sckIn != sckPrev_q);
  assign edgeEv     = masterSel ? (active_q && masterTick) : slaveEdge;
  assign sampleEdge = edgeIdx_q[0] == cpha;
  assign finalEdge  = edgeIdx_q == spsr_pkg::LAST_EDGE;
  assign serIn      = masterSel ? pinIn.misoIn : pinIn.mosiIn;
  assign busy       = masterSel ? active_q
                                : (slaveSel && edgeIdx_q != 4'h0);
  assign xferDone   = edgeEv && finalEdge;

  spsr_rate_div u_rate_div (
    .clock (clock),
    .rst_n (rst_n),
    .run   (active_q),
    .rate  (rateSel),
    .tick  (masterTick)
  );

  // ==========================================================
  // events and clear sequences
  logic       seqClr;
  logic       dataWrOk;
  logic       wcolSet;
  logic       ovrEvt;
  logic       modfEvt;
  logic       modfClr;
  logic       startXfer;

  assign seqClr    = dataAcc && armed_q;
  assign dataWrOk  = dataWr && (!doneFlag_q || armed_q) && !busy;
  assign wcolSet   = dataWr && busy;
  assign ovrEvt    = xferDone && doneFlag_q && !seqClr;
  assign modfEvt   = masterOn && !selectN;
  assign modfClr   = ctrlWr && modfArmed_q;
  assign startXfer = dataWrOk && masterOn && !modfEvt;

  // ==========================================================
  // flags: hardware set wins over software clear
  assign doneFlag_d  = xferDone || (doneFlag_q && !seqClr);
  assign wcolFlag_d  = wcolSet || (wcolFlag_q && !seqClr);
  assign ovrFlag_d   = ovrEvt || (ovrFlag_q && !statRd);
  assign modfFlag_d  = modfEvt || (modfFlag_q && !modfClr);
  assign armed_d     = statRd || (armed_q && !seqClr);
  assign modfArmed_d = (statRd && modfFlag_q) || (modfArmed_q && !ctrlWr);

  // ==========================================================
  // control register, fault drops enable and master
  logic [7:0] ctrlWritten;

  assign ctrlWritten = ctrlWr ? apbReq.pwdata[7:0] : ctrl_q;
  assign ctrl_d      = modfEvt ? (ctrlWritten
                       & ~(8'h01 << spsr_pkg::CR_PERIPH)
                       & ~(8'h01 << spsr_pkg::CR_MASTER))
                       : ctrlWritten;
  assign selCtl_d    = statWr ? apbReq.pwdata[2:0] : selCtl_q;

  // ==========================================================
  // receive buffer keeps the older byte on overrun
  assign rxBuf_d = (xferDone && !ovrEvt) ? shift_d : rxBuf_q;

  // ==========================================================
  // shift register
  always_comb begin
    shift_d = shift_q;
    if (dataWrOk) begin
      shift_d = apbReq.pwdata[7:0];
    end else if (edgeEv && finalEdge) begin
      shift_d = {shift_q[6:0], cpha ? serIn : rxBit_q};
    end else if (edgeEv && !sampleEdge &&
                 !(cpha && edgeIdx_q == 4'h0)) begin
      shift_d = {shift_q[6:0], rxBit_q};
    end
  end

  assign rxBit_d = (edgeEv && sampleEdge) ? serIn : rxBit_q;

  // ==========================================================
  // edge counter and master clock state
  always_comb begin
    edgeIdx_d  = edgeIdx_q;
    active_d   = active_q;
    sckLevel_d = sckLevel_q;
    if (startXfer) begin
      edgeIdx_d  = 4'h0;
      active_d   = 1'b1;
      sckLevel_d = 1'b0;
    end else if (modfEvt || !masterOn) begin
      active_d   = 1'b0;
      sckLevel_d = 1'b0;
      if (!slaveSel) begin
        edgeIdx_d = 4'h0;
      end else if (edgeEv) begin
        edgeIdx_d = edgeIdx_q + 4'h1;
      end
    end else if (edgeEv) begin
      edgeIdx_d  = edgeIdx_q + 4'h1;
      sckLevel_d = !sckLevel_q;
      if (finalEdge) begin
        active_d = 1'b0;
      end
    end
  end

  // ==========================================================
  // flip-flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q      <= spsr_pkg::CR_RESET;
      doneFlag_q  <= 1'b0;
      wcolFlag_q  <= 1'b0;
      ovrFlag_q   <= 1'b0;
      modfFlag_q  <= 1'b0;
      selCtl_q    <= spsr_pkg::SR_RESET[2:0];
      armed_q     <= 1'b0;
      modfArmed_q <= 1'b0;
    end else begin
      ctrl_q      <= ctrl_d;
      doneFlag_q  <= doneFlag_d;
      wcolFlag_q  <= wcolFlag_d;
      ovrFlag_q   <= ovrFlag_d;
      modfFlag_q  <= modfFlag_d;
      selCtl_q    <= selCtl_d;
      armed_q     <= armed_d;
      modfArmed_q <= modfArmed_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxBuf_q    <= 8'h00;
      shift_q    <= 8'h00;
      rxBit_q    <= 1'b0;
      edgeIdx_q  <= 4'h0;
      active_q   <= 1'b0;
      sckLevel_q <= 1'b0;
      sckPrev_q  <= 1'b0;
    end else begin
      rxBuf_q    <= rxBuf_d;
      shift_q    <= shift_d;
      rxBit_q    <= rxBit_d;
      edgeIdx_q  <= edgeIdx_d;
      active_q   <= active_d;
      sckLevel_q <= sckLevel_d;
      sckPrev_q  <= pinIn.sckIn;
    end
  end

  // ==========================================================
  // read data, reserved bit 3 reads zero
  logic [7:0] statView;
  logic [7:0] rdByte;

  assign statView = {doneFlag_q, wcolFlag_q, ovrFlag_q, modfFlag_q,
                     1'b0, selCtl_q};
  assign rdByte   = hitData ? rxBuf_q :
                    hitCtrl ? ctrl_q :
                    hitStat ? statView : 8'h00;

  assign apbRsp.prdata  = (busRd && hitAny) ? {24'h000000, rdByte}
                                            : 32'h00000000;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = apbAccess && !hitAny;

  // ==========================================================
  // interrupt and pins
  assign irq = irqEn && (doneFlag_q || modfFlag_q || ovrFlag_q);

  spsr_pin_drive u_pin_drive (
    .periphEn   (periphEn),
    .masterSel  (masterSel),
    .outDisable (outDisable),
    .cpol       (cpol),
    .sckLevel   (sckLevel_q),
    .txBit      (shift_q[7]),
    .pinOut     (pinOut)
  );

endmodule : spsr_core

// File: tb/spsr_core_monitor.sv
// Purpose: port checker for spsr_core
// Assumes: one clock domain, bound to the core instance
// Notes:   shadows the control bits that only software writes
`timescale 1ns/1ps

module spsr_core_monitor (
  // clock and reset
  input wire logic                    clock,
  input wire logic                    rst_n,
  // register bus
  input wire spsr_pkg::spsr_apb_req_t apbReq,
  input wire spsr_pkg::spsr_apb_rsp_t apbRsp,
  // pins and interrupt
  input wire spsr_pkg::spsr_pin_in_t  pinIn,
  input wire spsr_pkg::spsr_pin_out_t pinOut,
  input wire logic                    irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // decode and shadow bits
  wire  acc  = apbReq.psel & apbReq.penable;
  wire  wrSt = acc & apbReq.pwrite & (apbReq.paddr == spsr_pkg::ADDR_STAT);
  wire  wrCr = acc & apbReq.pwrite & (apbReq.paddr == spsr_pkg::ADDR_CTRL);
  wire  rdSt = acc & !apbReq.pwrite & (apbReq.paddr == spsr_pkg::ADDR_STAT);
  wire  oe   = pinOut.sckOe;
  logic outDis_q, softMode_q, softLvl_q, irqEn_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {outDis_q, softMode_q, softLvl_q, irqEn_q} <= 4'h0;
    end else begin
      if (wrSt) {outDis_q, softMode_q, softLvl_q} <= apbReq.pwdata[2:0];
      if (wrCr) irqEn_q <= apbReq.pwdata[7];
    end
  end
  // ==========================================================
  // properties
  sequence s_statRd; rdSt; endsequence
  sequence s_armMaster;
    wrCr && apbReq.pwdata[6] && apbReq.pwdata[4] && !softMode_q && pinIn.ssN;
  endsequence
  property p_rsvd; s_statRd |-> !apbRsp.prdata[3]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_ovrClr; s_statRd ##3 s_statRd |-> !apbRsp.prdata[5]; endproperty
  a_ovrClr: assert property (p_ovrClr) else $error("overrun kept");
  property p_sod; pinOut.mosiOe || pinOut.misoOe |-> !outDis_q; endproperty
  a_sod: assert property (p_sod) else $error("data out while off");
  property p_oeMode; pinOut.mosiOe |-> oe && !pinOut.misoOe; endproperty
  a_oeMode: assert property (p_oeMode) else $error("wrong data pin");
  property p_fault;
    oe && !softMode_q && !pinIn.ssN && !wrCr |-> ##[1:2] !oe;
  endproperty
  a_fault: assert property (p_fault) else $error("no drop");
  property p_softHold;
    oe && softMode_q && softLvl_q && !wrCr && !wrSt |=> oe;
  endproperty
  a_softHold: assert property (p_softHold) else $error("pin used");
  property p_softSel; oe && softMode_q && !softLvl_q && !wrCr |-> ##[1:2] !oe;
  endproperty
  a_softSel: assert property (p_softSel) else $error("soft level");
  property p_irq; irq |-> irqEn_q; endproperty
  a_irq: assert property (p_irq) else $error("irq while off");
  property p_idle;
    s_armMaster ##1 (oe && pinIn.ssN)
      |-> pinOut.sckOut == $past(apbReq.pwdata[3]);
  endproperty
  a_idle: assert property (p_idle) else $error("idle level");
endmodule : spsr_core_monitor

bind spsr_core spsr_core_monitor i_spsr_core_monitor (.clock(clock),
  .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .pinIn(pinIn),
  .pinOut(pinOut), .irq(irq));

// File: tb/spsr_slave_model.sv
// Purpose: behavioural external spi slave on the far side
// Assumes: lines sampled on the core clock
// Notes:   data out moves right after each capture edge
`timescale 1ns/1ps

module spsr_slave_model (
  // clock and mode
  input  wire logic       clock,
  input  wire logic       sel,
  input  wire logic       cpol,
  input  wire logic       cpha,
  // serial lines
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // byte side
  input  wire logic [7:0] txByte,
  output logic [7:0]      rxByte
);
  logic       sckPrev_q;
  logic [7:0] shift_q;
  // leading edge leaves idle; phase picks leading or trailing
  wire capture = (sck != sckPrev_q) & ((sck != cpol) ^ cpha);
  // a released line shows the inverse level
  assign miso = sel ? shift_q[7] : ~shift_q[7];
  always @(posedge clock) begin
    sckPrev_q <= sck;
    if (!sel) begin
      shift_q <= txByte;
    end else if (capture) begin
      rxByte  <= {rxByte[6:0], mosi};
      shift_q <= {shift_q[6:0], 1'b0};
    end
  end
endmodule : spsr_slave_model

// File: tb/spsr_core_tb.sv
// Purpose: register-level tests of spsr_core
// Assumes: zero-wait apb slave, external slave model on the pins
// Notes:   slave-mode traffic is driven by the bench itself
`timescale 1ns/1ps

module spsr_core_tb;
  // ==========================================================
  // signals
  localparam logic [11:0] AD = spsr_pkg::ADDR_DATA;
  localparam logic [11:0] AC = spsr_pkg::ADDR_CTRL;
  localparam logic [11:0] AS = spsr_pkg::ADDR_STAT;
  logic                    clock = 1'b0;
  logic                    rst_n = 1'b0;
  spsr_pkg::spsr_apb_req_t apbReq = '0;
  spsr_pkg::spsr_apb_rsp_t apbRsp;
  spsr_pkg::spsr_pin_in_t  pinIn;
  spsr_pkg::spsr_pin_out_t pinOut;
  logic irq, miso, er, sckPrev = 1'b0;
  logic ssN = 1'b1, pSel = 1'b0, mCpol = 1'b0, mCpha = 1'b0;
  logic tbSck = 1'b0, tbMosi = 1'b1;
  logic [7:0] pTx = 8'h00, pRx, rdv;
  logic [2:0] rc [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
  int errTotal = 0, testsRun = 0, edgeN = 0, t0 = 0, tLast = 0, cyc = 0;
  int e0;
  wire sckW  = pinOut.sckOe ? pinOut.sckOut : tbSck;
  wire mosiW = pinOut.mosiOe ? pinOut.mosiOut : tbMosi;
  wire misoW = pinOut.misoOe ? pinOut.misoOut : miso;
  assign pinIn = {sckW, mosiW, misoW, ssN};
  always #2 clock = ~clock;

  spsr_core i_spsr_core (.clock(clock), .rst_n(rst_n), .apbReq(apbReq),
    .apbRsp(apbRsp), .pinIn(pinIn), .pinOut(pinOut), .irq(irq));
  spsr_slave_model i_spsr_slave_model (.clock(clock), .sel(pSel),
    .cpol(mCpol), .cpha(mCpha), .sck(sckW), .mosi(mosiW), .miso(miso),
    .txByte(pTx), .rxByte(pRx));

  // serial clock edge count and span
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (sckW !== sckPrev) begin
      if (edgeN == 0) t0 = cyc;
      tLast = cyc;
      edgeN = edgeN + 1;
    end
    sckPrev = sckW;
  end

  // ==========================================================
  // tasks
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    testsRun++;
    if (g !== e) begin
      errTotal++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8
  task automatic chkN(input int g, input int e);
    testsRun++;
    if (g != e) begin
      errTotal++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chkN
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w,
                pwdata: {24'h0, d}};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (apbRsp.pready !== 1'b1);
    rdv = apbRsp.prdata[7:0];
    er = apbRsp.pslverr;
    apbReq <= '0;
  endtask : apb
  task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk8(rdv, e);
  endtask : rdChk
  task automatic xfer(input logic [7:0] d, input logic [7:0] t);
    pSel <= 1'b0;
    pTx <= t;
    apb(1'b1, AD, d);
    pSel <= 1'b1;
    edgeN = 0;
  endtask : xfer
  task automatic waitDone;
    do begin
      apb(1'b0, AS, 8'h00);
    end while (rdv[7] !== 1'b1);
    // let the far side and the edge counter take the last edge
    repeat (2) @(posedge clock);
  endtask : waitDone
  task automatic waitIrq;
    while (irq !== 1'b1) begin
      @(posedge clock);
    end
    repeat (2) @(posedge clock);
  endtask : waitIrq
  task automatic slvByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      tbMosi <= b[i];
      repeat (4) @(posedge clock);
      tbSck <= 1'b1;
      repeat (4) @(posedge clock);
      tbSck <= 1'b0;
    end
    repeat (4) @(posedge clock);
  endtask : slvByte
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // ==========================================================
  // tests
  initial begin
    repeat (20000) @(posedge clock);
    errTotal++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rdChk(AS, 8'h00);
    rdChk(AC, 8'h00);
    apb(1'b0, 12'h090, 8'h00);
    chk8({7'h0, er}, 8'h01);
    apb(1'b1, AS, 8'hf7);
    rdChk(AS, 8'h07);
    apb(1'b1, AS, 8'h00);
    for (int i = 0; i < 6; i++) begin
      mCpol <= i[1];
      mCpha <= i[0];
      tbSck <= i[1];
      apb(1'b1, AC, {2'b11, rc[i][2], 1'b1, i[1], i[0], rc[i][1:0]});
      xfer(8'h3c + 8'(i), 8'h96 ^ 8'(i));
      waitDone();
      chk8(rdv, 8'h80);
      chk8({7'h0, irq}, 8'h01);
      chk8(pRx, 8'h3c + 8'(i));
      chkN(edgeN, 16);
      chkN(tLast - t0, 15 * (2 << i));
      rdChk(AD, 8'h96 ^ 8'(i));
      rdChk(AS, 8'h00);
    end
    mCpha <= 1'b0;
    apb(1'b1, AC, 8'hf0);
    xfer(8'h81, 8'ha5);
    apb(1'b1, AD, 8'h7e);
    waitDone();
    chk8(rdv, 8'hc0);
    chk8(pRx, 8'h81);
    rdChk(AD, 8'ha5);
    rdChk(AS, 8'h00);
    xfer(8'h24, 8'h5c);
    waitIrq();
    e0 = edgeN;
    apb(1'b1, AD, 8'h99);
    rdChk(AS, 8'h80);
    repeat (4) @(posedge clock);
    chkN(edgeN, e0);
    rdChk(AD, 8'h5c);
    apb(1'b1, AS, 8'h04);
    @(negedge clock);
    chk8({7'h0, pinOut.mosiOe}, 8'h00);
    apb(1'b1, AS, 8'h00);
    @(negedge clock);
    chk8({7'h0, pinOut.mosiOe}, 8'h01);
    ssN <= 1'b0;
    waitIrq();
    ssN <= 1'b1;
    rdChk(AC, 8'ha0);
    apb(1'b1, AC, 8'h80);
    rdChk(AS, 8'h10);
    apb(1'b1, AC, 8'h80);
    rdChk(AS, 8'h00);
    apb(1'b1, AS, 8'h03);
    apb(1'b1, AC, 8'hf0);
    ssN <= 1'b0;
    rdChk(AS, 8'h03);
    apb(1'b1, AS, 8'h02);
    rdChk(AS, 8'h12);
    ssN <= 1'b1;
    apb(1'b1, AC, 8'h00);
    apb(1'b1, AS, 8'h00);
    pSel <= 1'b0;
    apb(1'b1, AC, 8'hc0);
    ssN <= 1'b0;
    slvByte(8'hc9);
    waitIrq();
    slvByte(8'h3e);
    rdChk(AS, 8'ha0);
    rdChk(AS, 8'h80);
    rdChk(AD, 8'hc9);
    rdChk(AS, 8'h00);
    ssN <= 1'b1;
    wrap_up();
  end
endmodule : spsr_core_tb
